/* File: bench/spi_partner.sv */
// Behavioural SPI slave on the far side of the port in master role
`timescale 1ns/1ps
module spi_partner (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       select_n,
    input  wire logic       cpol,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      shifter
);
    initial begin
        miso = 1'h0;
        shifter = 8'h00;
    end
    always @(negedge select_n) begin
        shifter = tx_byte;
        miso = tx_byte[7];
    end
    // Leading edge captures into the low bit, trailing edge drives the next high bit
    always @(sck) begin
        if (!select_n && (sck ^ cpol)) begin
            shifter = {shifter[6:0], mosi};
        end else if (!select_n) begin
            miso = shifter[7];
        end
    end
    // A released line shows the inverse of its last level
    always @(posedge select_n) miso = ~miso;
endmodule

/* File: bench/spi_port_assertions.sv */
// Checker of bus answers and serial clocking at the port's pins
`timescale 1ns/1ps
module spi_port_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        serial_clock_pin_out,
    input wire logic        serial_clock_pin_oe,
    input wire logic        serial_out_pin_oe,
    input wire logic        port_interrupt_flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [1:0] last;
    logic [3:0] rises;
    logic [3:0] rises_now;
    // Rising clock edges since the last byte, counted only while the pin was driven
    assign rises_now = rises + {3'h0, serial_clock_pin_out & ~last[0] & last[1]};
    always_ff @(posedge aclk) begin
        last <= {serial_clock_pin_oe, serial_clock_pin_out};
        rises <= (!aresetn || !serial_clock_pin_oe || port_interrupt_flag) ? 4'h0 : rises_now;
    end
    ////////////////////////////////////////
    a_irq_one_cycle: assert property (port_interrupt_flag |=> !port_interrupt_flag)
        else $error("byte flag too long");
    a_eight_clocks: assert property (port_interrupt_flag && serial_clock_pin_oe |-> rises_now == 4'h8)
        else $error("wrong clock count");
    a_clock_still: assert property (port_interrupt_flag && serial_clock_pin_oe
        |=> $stable(serial_clock_pin_out)[*2]) else $error("clock moved after byte");
    a_master_drives: assert property (serial_clock_pin_oe |-> serial_out_pin_oe)
        else $error("clock without data drive");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper bits set");
endmodule
bind spi_port spi_port_assertions chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe(serial_clock_pin_oe), .serial_out_pin_oe(serial_out_pin_oe),
    .port_interrupt_flag(port_interrupt_flag));

/* File: bench/tb.sv */
// Bench for the serial port: registers, select handling and master transfers
`timescale 1ns/1ps
module tb;
    import spi_port_pkg::*;
    logic        aclk, awready, wready, bvalid, arready, rvalid, sck, sck_oe, sdo, sdo_oe, irq, miso;
    logic        aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        tmatch = 1'h0, ss_n = 1'h1, cpol = 1'h0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [1:0]  rresp, bresp;
    logic [7:0]  tx = 8'h00, seen;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    int          seed = 32'hf057, miscompares = 0, comparisons = 0;
    spi_port dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_match(tmatch), .serial_clock_pin_in(sck_oe ? sck : cpol),
        .serial_clock_pin_out(sck), .serial_clock_pin_oe(sck_oe), .serial_in_pin(miso), .serial_out_pin(sdo),
        .serial_out_pin_oe(sdo_oe), .slave_select_n_pin(ss_n), .port_interrupt_flag(irq));
    spi_partner far_end (.sck(sck), .mosi(sdo), .select_n(ss_n), .cpol(cpol), .tx_byte(tx), .miso(miso),
        .shifter(seen));
    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) tmatch <= ($random(seed) & 3) == 0;
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'h0;
        chk(what, exp, rdata);
    endtask
    function automatic logic [7:0] ctrl(input logic en, input logic clock_idle_polarity, input logic [3:0] mode);
        return {2'h0, en, clock_idle_polarity, mode};
    endfunction
    function automatic logic [31:0] stat(input logic [7:0] w, input logic full);
        return {24'h00_0000, w[7:6], 5'h00, full};
    endfunction
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        wrap_up();
    end
    ////////////////////////////////////////
    initial begin
        logic [7:0] b;
        logic       clock_idle_polarity;
        logic [3:0] modes [5];
        modes = '{MODE_MASTER_DIV4, MODE_MASTER_DIV16, MODE_MASTER_DIV64, MODE_MASTER_TIMER, MODE_MASTER_RELOAD};
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        rd(OFF_CONTROL_ONE, {24'h00_0000, CONTROL_ONE_RESET}, "control reset");
        rd(OFF_STATUS, {24'h00_0000, STATUS_RESET}, "status reset");
        rd(OFF_RELOAD, {24'h00_0000, RELOAD_RESET}, "reload reset");
        b = 8'($random(seed)) & 8'hdf;
        wr(OFF_CONTROL_ONE, b);
        rd(OFF_CONTROL_ONE, {24'h00_0000, b}, "control rw");
        rd(4'h2, {24'h00_0000, b}, "unaligned control");
        chk("unaligned resp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, rresp});
        wr(OFF_STATUS, 8'hff);
        rd(OFF_STATUS, stat(8'hff, 1'h0), "status ro");
        b = 8'($random(seed)) & 8'h03;
        wr(OFF_RELOAD, b);
        chk("write resp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, bresp});
        rd(OFF_RELOAD, {24'h00_0000, b}, "reload rw");
        $display("register test done");
        wr(OFF_CONTROL_ONE, ctrl(1'h1, 1'h0, MODE_SLAVE_SELECT));
        repeat (6) @(posedge aclk);
        chk("deselected drive", 32'h0000_0000, {31'h0000_0000, sdo_oe});
        chk("slave clock drive", 32'h0000_0000, {31'h0000_0000, sck_oe});
        ss_n <= 1'h0;
        repeat (6) @(posedge aclk);
        chk("selected drive", 32'h0000_0001, {31'h0000_0000, sdo_oe});
        ss_n <= 1'h1;
        $display("select test done");
        wr(OFF_STATUS, 8'h40);
        foreach (modes[i]) begin
            clock_idle_polarity = 1'($random(seed));
            b = 8'($random(seed));
            cpol <= clock_idle_polarity;
            tx <= 8'($random(seed));
            wr(OFF_CONTROL_ONE, ctrl(1'h0, clock_idle_polarity, modes[i]));
            wr(OFF_CONTROL_ONE, ctrl(1'h1, clock_idle_polarity, modes[i]));
            ss_n <= 1'h0;
            wr(OFF_BUFFER, b);
            wr(OFF_BUFFER, ~b);
            do @(posedge aclk); while (!irq);
            ss_n <= 1'h1;
            chk("clock drive", 32'h0000_0001, {31'h0000_0000, sck_oe});
            rd(OFF_STATUS, stat(8'h40, 1'h1), "full set");
            rd(OFF_CONTROL_ONE, {24'h00_0000, ctrl(1'h1, clock_idle_polarity, modes[i]) | 8'h80}, "collision");
            rd(OFF_BUFFER, {24'h00_0000, tx}, "received");
            chk("sent", {24'h00_0000, b}, {24'h00_0000, seen});
            rd(OFF_STATUS, stat(8'h40, 1'h0), "full clear");
            wr(OFF_BUFFER, b);
            rd(OFF_BUFFER, {24'h00_0000, tx}, "blocked write");
            $display("transfer test %0d done", i);
        end
        wrap_up();
    end
endmodule

/* File: inc/spi_port_pkg.sv */
// Package with register map, field positions and codes of the serial port in SPI mode
package spi_port_pkg;
    localparam logic [3:0] OFF_CONTROL_ONE = 4'h0;
    localparam logic [3:0] OFF_STATUS      = 4'h4;
    localparam logic [3:0] OFF_BUFFER      = 4'h8;
    localparam logic [3:0] OFF_RELOAD      = 4'hc;
    localparam logic [3:0] OFF_CONTROL_THREE = 4'h4 + 4'h8 - 4'h8 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;
    localparam int CON_WRITE_COLLISION_FLAG_BIT   = 7;
    localparam int CON_ENABLE_BIT = 5;
    localparam int CON_CKP_BIT    = 4;
    localparam int STAT_SMP_BIT   = 7;
    localparam int STAT_CKE_BIT   = 6;
    localparam int STAT_BF_BIT    = 0;
    localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam logic [7:0] RELOAD_RESET      = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Mode codes in control bits 3:0
    localparam logic [3:0] MODE_MASTER_DIV4    = 4'h0;
    localparam logic [3:0] MODE_MASTER_DIV16   = 4'h1;
    localparam logic [3:0] MODE_MASTER_DIV64   = 4'h2;
    localparam logic [3:0] MODE_MASTER_TIMER   = 4'h3;
    localparam logic [3:0] MODE_SLAVE_SELECT   = 4'h4;
    localparam logic [3:0] MODE_SLAVE_NOSELECT = 4'h5;
    localparam logic [3:0] MODE_MASTER_RELOAD  = 4'ha;
    localparam int BITS_PER_BYTE = 8;
endpackage

/* File: rtl/spi_port.sv */
// Serial port in SPI mode with AXI4-Lite register access
`timescale 1ns/1ps
module spi_port (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        timer_match,
    input  wire logic        serial_clock_pin_in,
    output logic             serial_clock_pin_out,
    output logic             serial_clock_pin_oe,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             serial_out_pin_oe,
    input  wire logic        slave_select_n_pin,
    output logic             port_interrupt_flag
);
    import spi_port_pkg::*;

    typedef struct packed {
        logic       aw_seen;
        logic [3:0] aw_addr;
        logic       w_seen;
        logic [7:0] w_data;
        logic       w_lane;
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] control_one;
        logic [1:0] status_top;
        logic       buffer_full_flag;
        logic [7:0] data_buffer_reg;
        logic [7:0] address_reload_reg;
        logic [7:0] shift_reg;
        logic [3:0] bit_count;
        logic       busy;
        logic [8:0] div_count;
        logic       sck_level;
        logic       sample_bit;
        logic       late_sample;
        logic [2:0] sck_sync;
        logic [1:0] sel_sync;
        logic [1:0] sdi_sync;
        logic       tmr_sync;
        logic       tmr_half;
        logic       sdo;
        logic       sdo_oe;
        logic       sck_oe;
        logic       irq;
    } state_t;

    state_t r;
    state_t next_r;

    // Half-period of the master clock in core cycles, minus one
    function automatic logic [8:0] half_period(input logic [3:0] mode, input logic [7:0] reload);
        case (mode)
            MODE_MASTER_DIV4:   half_period = 9'd1;
            MODE_MASTER_DIV16:  half_period = 9'd7;
            MODE_MASTER_DIV64:  half_period = 9'd31;
            MODE_MASTER_RELOAD: half_period = {reload, 1'b1};
            default:            half_period = 9'd1;
        endcase
    endfunction

    logic [3:0] mode;
    logic       is_master;
    logic       enabled;
    logic       clock_idle_polarity;
    logic       cke;
    logic       sample_phase_select;
    logic       sel_used;
    logic       selected;
    logic       sck_rise;
    logic       sck_fall;
    logic       lead_edge;
    logic       trail_edge;
    logic       wr_fire;
    logic       rd_fire;
    logic       buf_write;
    logic       tick;

    assign mode      = r.control_one[3:0];
    assign is_master = (mode <= MODE_MASTER_TIMER) || (mode == MODE_MASTER_RELOAD);
    assign enabled   = r.control_one[CON_ENABLE_BIT];
    assign clock_idle_polarity       = r.control_one[CON_CKP_BIT];
    assign cke       = r.status_top[STAT_CKE_BIT-6];
    assign sample_phase_select       = r.status_top[STAT_SMP_BIT-6];
    assign sel_used  = (mode == MODE_SLAVE_SELECT);
    assign selected  = !sel_used || !r.sel_sync[1];
    assign sck_rise  = r.sck_sync[1] && !r.sck_sync[2];
    assign sck_fall  = !r.sck_sync[1] && r.sck_sync[2];
    // Leading edge leaves idle level; with cke data changes on active-to-idle edge
    assign lead_edge  = clock_idle_polarity ? sck_fall : sck_rise;
    assign trail_edge = clock_idle_polarity ? sck_rise : sck_fall;
    assign wr_fire = r.aw_seen && r.w_seen && !r.bvalid;
    assign rd_fire = s_axi_arvalid && r.arready;
    assign buf_write = wr_fire && r.aw_addr == OFF_BUFFER && r.w_lane;
    assign tick = (mode == MODE_MASTER_TIMER) ? (r.tmr_sync && r.tmr_half) : (r.div_count == 9'd0);

    always_comb begin
        logic shift_now;
        logic sample_now;
        logic byte_done;
        shift_now  = 1'b0;
        sample_now = 1'b0;
        byte_done  = 1'b0;
        next_r = r;
        next_r.sck_sync = {r.sck_sync[1:0], serial_clock_pin_in};
        next_r.sel_sync = {r.sel_sync[0], slave_select_n_pin};
        next_r.sdi_sync = {r.sdi_sync[0], serial_in_pin};
        next_r.tmr_sync = timer_match;
        next_r.irq = 1'b0;
        next_r.late_sample = 1'b0;

        ////////////////////////////////////////////////////////////////////
        // AXI4-Lite slave
        next_r.awready = !r.aw_seen && !s_axi_awvalid ? 1'b1 : !r.aw_seen;
        next_r.wready  = !r.w_seen;
        if (s_axi_awvalid && r.awready && !r.aw_seen) begin
            next_r.aw_seen = 1'b1;
            next_r.aw_addr = {s_axi_awaddr[3:2], 2'b00};
            next_r.awready = 1'b0;
        end
        if (s_axi_wvalid && r.wready && !r.w_seen) begin
            next_r.w_seen = 1'b1;
            next_r.w_data = s_axi_wdata[7:0];
            next_r.w_lane = s_axi_wstrb[0];
            next_r.wready = 1'b0;
        end
        if (wr_fire) begin
            next_r.bvalid = 1'b1;
            next_r.bresp  = RESP_OKAY;
            if (r.w_lane) begin
                case (r.aw_addr)
                    OFF_CONTROL_ONE: next_r.control_one = r.w_data;
                    OFF_STATUS:      next_r.status_top = r.w_data[7:6];
                    OFF_BUFFER: begin
                        if (r.busy || r.control_one[CON_WRITE_COLLISION_FLAG_BIT]) begin
                            next_r.control_one[CON_WRITE_COLLISION_FLAG_BIT] = 1'b1;
                        end else begin
                            next_r.data_buffer_reg = r.w_data;
                            next_r.shift_reg       = r.w_data;
                            next_r.busy            = is_master && enabled;
                            next_r.sdo             = r.w_data[7];
                        end
                    end
                    OFF_RELOAD:      next_r.address_reload_reg = r.w_data;
                    default:         next_r.bresp = RESP_SLVERR;
                endcase
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid  = 1'b0;
            next_r.aw_seen = 1'b0;
            next_r.w_seen  = 1'b0;
            next_r.awready = 1'b1;
            next_r.wready  = 1'b1;
        end
        next_r.arready = !r.rvalid && !rd_fire;
        if (rd_fire) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = RESP_OKAY;
            next_r.rdata  = 32'h0000_0000;
            case ({s_axi_araddr[3:2], 2'b00})
                OFF_CONTROL_ONE: next_r.rdata[7:0] = r.control_one;
                OFF_STATUS:      next_r.rdata[7:0] = {r.status_top, 5'b0_0000, r.buffer_full_flag};
                OFF_BUFFER: begin
                    next_r.rdata[7:0]       = r.data_buffer_reg;
                    next_r.buffer_full_flag = 1'b0;
                end
                OFF_RELOAD:      next_r.rdata[7:0] = r.address_reload_reg;
                default:         next_r.rresp = RESP_SLVERR;
            endcase
        end
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid  = 1'b0;
            next_r.arready = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////
        // Shift engine
        if (is_master) begin
            next_r.sck_oe = enabled;
            next_r.sdo_oe = enabled;
            next_r.tmr_half = r.tmr_sync ? !r.tmr_half : r.tmr_half;
            // Capture one cycle after the sample edge: data-in lags our own clock by the synchroniser
            sample_now = r.late_sample && r.busy;
            if (r.busy) begin
                next_r.div_count = (r.div_count == 9'd0) ?
                    half_period(mode, r.address_reload_reg) : r.div_count - 9'd1;
                if (tick) begin
                    next_r.sck_level = !r.sck_level;
                    // Leading edge samples when cke is set, trailing edge otherwise
                    if ((r.sck_level == clock_idle_polarity) == cke) begin
                        next_r.late_sample = 1'b1;
                    end else begin
                        shift_now = 1'b1;
                    end
                end
            end else begin
                next_r.sck_level = clock_idle_polarity;
                next_r.div_count = half_period(mode, r.address_reload_reg);
            end
        end else begin
            next_r.sck_oe = 1'b0;
            next_r.sck_level = clock_idle_polarity;
            next_r.sdo_oe = enabled && selected && !(sel_used && r.sel_sync[1]);
            if (enabled && selected) begin
                if (cke) begin
                    sample_now = lead_edge;
                    shift_now  = trail_edge;
                end else begin
                    sample_now = trail_edge;
                    shift_now  = lead_edge;
                end
            end
        end

        // Sample on one edge, move on the other; smp holds the master sample and shifts it in on the move edge
        if (sample_now) begin
            next_r.sample_bit = r.sdi_sync[1];
            if (!sample_phase_select || !is_master) begin
                next_r.shift_reg = {r.shift_reg[6:0], r.sdi_sync[1]};
                next_r.bit_count = r.bit_count + 4'd1;
                byte_done = (r.bit_count == 4'(BITS_PER_BYTE - 1));
            end
        end
        if (shift_now) begin
            if (sample_phase_select && is_master && r.bit_count != 4'(BITS_PER_BYTE)) begin
                next_r.shift_reg = {r.shift_reg[6:0], r.sample_bit};
                next_r.bit_count = r.bit_count + 4'd1;
                byte_done = (r.bit_count == 4'(BITS_PER_BYTE - 1));
                next_r.sdo = r.shift_reg[6];
            end else begin
                next_r.sdo = r.shift_reg[7];
            end
        end
        if (byte_done) begin
            next_r.data_buffer_reg  = next_r.shift_reg;
            next_r.buffer_full_flag = 1'b1;
            next_r.irq              = 1'b1;
            next_r.bit_count        = 4'd0;
            next_r.busy             = 1'b0;
            next_r.sck_level        = clock_idle_polarity;
        end
        if (!enabled || (sel_used && r.sel_sync[1])) begin
            next_r.bit_count = 4'd0;
            next_r.busy      = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
            r.control_one <= CONTROL_ONE_RESET;
            r.address_reload_reg <= RELOAD_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign serial_clock_pin_out = r.sck_level;
    assign serial_clock_pin_oe  = r.sck_oe;
    assign serial_out_pin       = r.sdo;
    assign serial_out_pin_oe    = r.sdo_oe;
    assign port_interrupt_flag  = r.irq;
endmodule
